// ===== verilog/bank_sched_pkg.sv
/*
  Shared constants and types for the cross-bank command scheduler pair:
  command pin encodings, bank states and timing counts.
  Assumes one 100 MHz clock shared by controller and device ends.
*/
package bank_sched_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W    = 3;
  localparam int CNT_W     = 6;

  // Timing in ps, rounded up to clocks (clock period 10 ns)
  localparam int CLK_PERIOD_PS = 10000;
  localparam int T_RP_PS       = 15000;
  localparam int T_RCD_PS      = 15000;
  localparam int T_WR_PS       = 15000;
  localparam int T_WTR_PS      = 7500;
  localparam int T_XSNR_CK     = 200;
  localparam int CAS_LAT       = 5;
  localparam int BURST_LEN     = 8;
  localparam int WTR_MIN_CK    = 2;

  localparam int RP_CK   = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RCD_CK  = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_CK   = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WTR_RAW = (T_WTR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WTR_CK  = (WTR_RAW > WTR_MIN_CK) ? WTR_RAW : WTR_MIN_CK;
  localparam int HALF_BL = BURST_LEN / 2;
  localparam int WL_CK   = CAS_LAT - 1;

  // Cross-bank minimum delays after auto precharge commands
  localparam int WRA_TO_RD  = (CAS_LAT - 1) + HALF_BL + WTR_CK;
  localparam int WRA_TO_WR  = HALF_BL;
  localparam int RDA_TO_RD  = HALF_BL;
  localparam int RDA_TO_WR  = HALF_BL + 2;
  localparam int AP_TO_ROW  = 1;
  // Read burst end and write recovery end, measured from the command
  localparam int RD_BURST_CK = HALF_BL;
  localparam int WR_REC_CK   = WL_CK + HALF_BL + WR_CK;

  // Pin pattern {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PAT_NOP  = 4'h7;
  localparam logic [3:0] PAT_ACT  = 4'h3;
  localparam logic [3:0] PAT_RD   = 4'h5;
  localparam logic [3:0] PAT_WR   = 4'h4;
  localparam logic [3:0] PAT_PRE  = 4'h2;
  localparam logic [3:0] PAT_REF  = 4'h1;
  localparam logic [3:0] PAT_LMR  = 4'h0;
  localparam logic [3:0] PAT_DES  = 4'h8;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_LMR = 3'h6
  } cmd_t;

  // Gray along idle -> activating -> active -> read -> write -> precharge
  typedef enum logic [2:0] {
    BK_IDLE  = 3'h0,
    BK_ACTV  = 3'h1,
    BK_ROW   = 3'h3,
    BK_READ  = 3'h2,
    BK_WRITE = 3'h6,
    BK_PRE   = 3'h4
  } bank_state_t;

  // Decode the sampled pins into a command; deselect and nop fold to nop
  function automatic cmd_t decode_cmd(input logic [3:0] pins);
    cmd_t c;
    c = CMD_NOP;
    if (!pins[3])
    begin
      unique case (pins[2:0])
        3'h3:    c = CMD_ACT;
        3'h5:    c = CMD_RD;
        3'h4:    c = CMD_WR;
        3'h2:    c = CMD_PRE;
        3'h1:    c = CMD_REF;
        3'h0:    c = CMD_LMR;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [CNT_W-1:0] cnt(input int v);
    return CNT_W'(v);
  endfunction

endpackage

// ===== verilog/ddr_cmd_if.sv
/*
  Command pins between the controller end and the device end.
  Assumes both ends share clk; all pins are one-way.
*/
`timescale 1ns/1ps
interface ddr_cmd_if;
  import bank_sched_pkg::*;

  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] bank;
  logic              auto_pre;

  modport ctrl (
    output cke,
    output cs_n,
    output ras_n,
    output cas_n,
    output we_n,
    output bank,
    output auto_pre
  );

  modport dev (
    input  cke,
    input  cs_n,
    input  ras_n,
    input  cas_n,
    input  we_n,
    input  bank,
    input  auto_pre
  );
endinterface

// ===== verilog/bank_tracker.sv
/*
  One bank's state and countdown, as seen on the command pins.
  Assumes commands are already decoded and legal-checked by the owner.
*/
`timescale 1ns/1ps
module bank_tracker
  import bank_sched_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hit,
  input  cmd_t             cmd,
  input  wire logic        auto_pre,
  output bank_state_t      state,
  output logic             ap_access
);

  typedef struct packed {
    bank_state_t      st;
    logic [CNT_W-1:0] cnt;
    logic             ap;
  } trk_t;

  trk_t s_r;
  trk_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (s_r.cnt != '0)
      s_nxt.cnt = s_r.cnt - cnt(1);
    // The pins keep the last bank during NOPs, so only a real bank
    // command may take over from the countdown below
    if (hit && cmd inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE})
    begin
      unique case (cmd)
        CMD_ACT:
        begin
          s_nxt.st  = BK_ACTV;
          s_nxt.cnt = cnt(RCD_CK);
        end
        CMD_RD:
        begin
          s_nxt.st  = BK_READ;
          s_nxt.ap  = auto_pre;
          s_nxt.cnt = cnt(RD_BURST_CK);
        end
        CMD_WR:
        begin
          s_nxt.st  = BK_WRITE;
          s_nxt.ap  = auto_pre;
          s_nxt.cnt = cnt(WR_REC_CK);
        end
        CMD_PRE:
        begin
          s_nxt.st  = BK_PRE;
          s_nxt.ap  = 1'b0;
          s_nxt.cnt = cnt(RP_CK);
        end
        default: ;
      endcase
    end
    else if (s_r.cnt == cnt(1) || s_r.cnt == '0)
    begin
      unique case (s_r.st)
        BK_ACTV: s_nxt.st = BK_ROW;
        BK_READ, BK_WRITE:
        begin
          // Access period ends; auto precharge starts its precharge period
          if (s_r.ap)
          begin
            s_nxt.st  = BK_PRE;
            s_nxt.ap  = 1'b0;
            s_nxt.cnt = cnt(RP_CK);
          end
          else
            s_nxt.st = BK_ROW;
        end
        BK_PRE:  s_nxt.st = BK_IDLE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '{st: BK_IDLE, cnt: '0, ap: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign state     = s_r.st;
  assign ap_access = s_r.ap;

endmodule

// ===== verilog/sched_ctrl.sv
/*
  Controller end: issues user commands onto the pins only once cross-bank minimum delays and the bank
  state, which lags the pins by one clock, allow it; otherwise fills the cycle with NOP.
  Assumes the user holds a request until it is accepted.
*/
`timescale 1ns/1ps
module sched_ctrl
  import bank_sched_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              req_valid,
  input  cmd_t                   req_cmd,
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic              req_auto_pre,
  output logic                   req_ready,
  output logic                   cmd_illegal,
  ddr_cmd_if.ctrl                pins
);

  typedef struct packed {
    logic [3:0]        pat;
    logic [BANK_W-1:0] bank;
    logic              ap;
    logic              ready;
    logic              illegal;
    logic [CNT_W-1:0]  rd_wait;
    logic [CNT_W-1:0]  wr_wait;
    logic [CNT_W-1:0]  row_wait;
    logic [CNT_W-1:0]  xsnr_wait;
  } ctl_t;

  ctl_t        s_r;
  ctl_t        s_nxt;
  bank_state_t st [NUM_BANKS];
  logic        apa [NUM_BANKS];
  logic        all_idle;
  logic        own_ok;
  logic        cross_ok;
  logic        fire;
  cmd_t        pin_cmd;

  // ----------------------------------------
  // Mirror of bank state
  // ----------------------------------------
  assign pin_cmd = decode_cmd(s_r.pat);

  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    bank_tracker u_trk (
      .clk       (clk),
      .reset_n   (reset_n),
      .hit       (s_r.bank == BANK_W'(b)),
      .cmd       (pin_cmd),
      .auto_pre  (s_r.ap),
      .state     (st[b]),
      .ap_access (apa[b])
    );
  end

  always_comb
  begin
    all_idle = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++)
      if (st[b] != BK_IDLE)
        all_idle = 1'b0;
  end

  // ----------------------------------------
  // Legality
  // ----------------------------------------
  always_comb
  begin
    own_ok = 1'b0;
    unique case (req_cmd)
      CMD_ACT:         own_ok = st[req_bank] == BK_IDLE;
      CMD_RD, CMD_WR:  own_ok = st[req_bank] == BK_ROW;
      CMD_PRE:         own_ok = st[req_bank] == BK_ROW ||
                                st[req_bank] == BK_IDLE;
      CMD_REF, CMD_LMR: own_ok = all_idle;
      CMD_NOP:         own_ok = 1'b1;
      default:         own_ok = 1'b0;
    endcase
  end

  // Cross-bank waits also keep read and write data apart on the bus
  always_comb
  begin
    unique case (req_cmd)
      CMD_RD:           cross_ok = s_r.rd_wait == '0;
      CMD_WR:           cross_ok = s_r.wr_wait == '0;
      CMD_ACT, CMD_PRE: cross_ok = s_r.row_wait == '0;
      default:          cross_ok = 1'b1;
    endcase
  end

  assign fire = req_valid && own_ok && cross_ok && s_r.xsnr_wait == '0;

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    return (v == '0) ? v : v - cnt(1);
  endfunction

  // A wait loaded with d-1 is zero before the edge d clocks on, so the
  // next command may go out at exactly the minimum delay
  function automatic logic [CNT_W-1:0] maxc(input logic [CNT_W-1:0] a,
                                          input int b);
    return (a > cnt(b - 1)) ? a : cnt(b - 1);
  endfunction

  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.rd_wait   = dec(s_r.rd_wait);
    s_nxt.wr_wait   = dec(s_r.wr_wait);
    s_nxt.row_wait  = dec(s_r.row_wait);
    s_nxt.xsnr_wait = dec(s_r.xsnr_wait);
    s_nxt.pat       = PAT_NOP;
    s_nxt.ready     = fire;
    s_nxt.illegal   = req_valid && !own_ok;
    if (fire)
    begin
      s_nxt.bank = req_bank;
      s_nxt.ap   = req_auto_pre;
      unique case (req_cmd)
        CMD_ACT: s_nxt.pat = PAT_ACT;
        CMD_PRE: s_nxt.pat = PAT_PRE;
        CMD_REF: s_nxt.pat = PAT_REF;
        CMD_LMR: s_nxt.pat = PAT_LMR;
        CMD_RD:
        begin
          s_nxt.pat      = PAT_RD;
          s_nxt.rd_wait  = maxc(s_nxt.rd_wait, RDA_TO_RD);
          s_nxt.wr_wait  = maxc(s_nxt.wr_wait, RDA_TO_WR);
          s_nxt.row_wait = maxc(s_nxt.row_wait, AP_TO_ROW);
        end
        CMD_WR:
        begin
          s_nxt.pat      = PAT_WR;
          s_nxt.rd_wait  = maxc(s_nxt.rd_wait, WRA_TO_RD);
          s_nxt.wr_wait  = maxc(s_nxt.wr_wait, WRA_TO_WR);
          s_nxt.row_wait = maxc(s_nxt.row_wait, AP_TO_ROW);
        end
        default: s_nxt.pat = PAT_NOP;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '{pat: PAT_DES, bank: '0, ap: 1'b0, ready: 1'b0,
               illegal: 1'b0, rd_wait: '0, wr_wait: '0, row_wait: '0,
               xsnr_wait: cnt(T_XSNR_CK % 64)};
    else
      s_r <= s_nxt;
  end

  assign pins.cke      = 1'b1;
  assign pins.cs_n     = s_r.pat[3];
  assign pins.ras_n    = s_r.pat[2];
  assign pins.cas_n    = s_r.pat[1];
  assign pins.we_n     = s_r.pat[0];
  assign pins.bank     = s_r.bank;
  assign pins.auto_pre = s_r.ap;
  assign req_ready     = s_r.ready;
  assign cmd_illegal   = s_r.illegal;

endmodule

// ===== verilog/sched_dev.sv
/*
  Device end: decodes the command pins each rising edge, tracks every
  bank and reports the executed command and bank states.
  Notes on behaviour are in this header.
*/
`timescale 1ns/1ps
module sched_dev
  import bank_sched_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  ddr_cmd_if.dev                 pins,
  output logic                   exec_valid,
  output cmd_t                   exec_cmd,
  output logic [BANK_W-1:0]      exec_bank,
  output logic [NUM_BANKS-1:0]   bank_idle,
  output logic [NUM_BANKS-1:0]   bank_busy
);

  typedef struct packed {
    logic              cke_prev;
    logic              valid;
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic [NUM_BANKS-1:0] idle;
    logic [NUM_BANKS-1:0] busy;
  } dev_t;

  dev_t        s_r;
  dev_t        s_nxt;
  cmd_t        cur;
  logic        live;
  bank_state_t st [NUM_BANKS];
  logic        apa [NUM_BANKS];

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Deselect and NOP both decode to no command, so trackers keep counting
  assign cur  = decode_cmd({pins.cs_n, pins.ras_n, pins.cas_n,
                            pins.we_n});
  assign live = pins.cke && s_r.cke_prev;

  // Each bank tracker only sees its own bank; others keep running
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    bank_tracker u_trk (
      .clk       (clk),
      .reset_n   (reset_n),
      .hit       (live && pins.bank == BANK_W'(b)),
      .cmd       (cur),
      .auto_pre  (pins.auto_pre),
      .state     (st[b]),
      .ap_access (apa[b])
    );
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.cke_prev = pins.cke;
    s_nxt.valid    = live && cur != CMD_NOP;
    s_nxt.cmd      = cur;
    s_nxt.bank     = pins.bank;
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      s_nxt.idle[b] = st[b] == BK_IDLE;
      s_nxt.busy[b] = apa[b];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '{cke_prev: 1'b0, valid: 1'b0, cmd: CMD_NOP, bank: '0,
               idle: '1, busy: '0};
    else
      s_r <= s_nxt;
  end

  assign exec_valid = s_r.valid;
  assign exec_cmd   = s_r.cmd;
  assign exec_bank  = s_r.bank;
  assign bank_idle  = s_r.idle;
  assign bank_busy  = s_r.busy;

endmodule

// ===== verif/sched_monitor.sv
/*
  Checker on the command pins between the two scheduler ends.
  Assumes it sits beside the interface and shares its clock.
*/
`timescale 1ns/1ps
module sched_monitor
  import bank_sched_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic              auto_pre
);
  typedef struct packed {
    logic [CNT_W-1:0]     since_rd;
    logic [CNT_W-1:0]     since_wr;
    logic [NUM_BANKS-1:0] open;
  } mon_t;

  mon_t       st_r;
  mon_t       st_nxt;
  logic [3:0] pat;
  logic       rd;
  logic       wr;
  logic       act;

  assign pat = {cs_n, ras_n, cas_n, we_n};
  assign rd  = (pat == PAT_RD);
  assign wr  = (pat == PAT_WR);
  assign act = (pat == PAT_ACT);

  // Counters saturate so a long idle stretch never wraps to a small gap
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.since_rd != '1)
      st_nxt.since_rd = st_r.since_rd + CNT_W'(1);
    if (st_r.since_wr != '1)
      st_nxt.since_wr = st_r.since_wr + CNT_W'(1);
    if (rd)
      st_nxt.since_rd = CNT_W'(1);
    if (wr)
      st_nxt.since_wr = CNT_W'(1);
    if (act)
      st_nxt.open[bank] = 1'b1;
    if ((rd || wr) && auto_pre)
      st_nxt.open[bank] = 1'b0;
    if (pat == PAT_PRE)
      st_nxt.open[bank] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      st_r <= '{since_rd: '1, since_wr: '1, open: '0};
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------
  // Pin timing and bank row state
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_cke_held: assert property (cke)
    else $error("clock enable dropped");
  a_rd_after_rd: assert property (rd |-> st_r.since_rd >= RDA_TO_RD)
    else $error("read too soon after read");
  a_wr_after_rd: assert property (wr |-> st_r.since_rd >= RDA_TO_WR)
    else $error("write too soon after read");
  a_rd_after_wr: assert property (rd |-> st_r.since_wr >= WRA_TO_RD)
    else $error("read too soon after write");
  a_wr_after_wr: assert property (wr |-> st_r.since_wr >= WRA_TO_WR)
    else $error("write too soon after write");
  a_ref_all_idle: assert property ((pat == PAT_REF || pat == PAT_LMR)
    |-> st_r.open == '0)
    else $error("refresh with open row");
  a_col_open_row: assert property ((rd || wr) |-> st_r.open[bank])
    else $error("column command to closed bank");
  a_act_closed: assert property (act |-> !st_r.open[bank])
    else $error("activate to open bank");
endmodule

// ===== verif/tb.sv
/*
  Testbench: drives the controller user side, watches the device end,
  and drives a second device end directly with faulty pin patterns.
  Assumes a 100 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module tb
  import bank_sched_pkg::*;
();
  typedef struct packed {
    cmd_t       cmd;
    logic [2:0] bank;
    logic       ap;
    logic [7:0] gap;
  } row_t;

  logic                 clk = 1'b0;
  logic                 reset_n;
  logic                 req_valid;
  cmd_t                 req_cmd;
  logic [BANK_W-1:0]    req_bank;
  logic                 req_auto_pre;
  logic                 req_ready;
  logic                 cmd_illegal;
  logic                 exec_valid;
  cmd_t                 exec_cmd;
  logic [BANK_W-1:0]    exec_bank;
  logic [NUM_BANKS-1:0] bank_idle;
  logic [NUM_BANKS-1:0] bank_busy;
  logic                 x_valid;
  cmd_t                 x_cmd;
  logic [BANK_W-1:0]    x_bank;
  int                   n_fail = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  int                   last = 0;
  logic [5:0]           exp_q[$];
  // Gap 0 means the first command, whose spacing is not judged
  row_t rows[11] = '{
    '{CMD_ACT, 3'h0, 1'b0, 8'h00}, '{CMD_ACT, 3'h1, 1'b0, 8'h01},
    '{CMD_ACT, 3'h2, 1'b0, 8'h01}, '{CMD_ACT, 3'h3, 1'b0, 8'h01},
    '{CMD_RD,  3'h0, 1'b0, 8'h01}, '{CMD_RD,  3'h1, 1'b1, 8'h04},
    '{CMD_WR,  3'h2, 1'b0, 8'h06}, '{CMD_WR,  3'h3, 1'b1, 8'h04},
    '{CMD_RD,  3'h0, 1'b0, 8'h0A}, '{CMD_PRE, 3'h2, 1'b0, 8'h01},
    '{CMD_ACT, 3'h4, 1'b0, 8'h01}};
  logic [7:0] far[5] = '{8'h18, 8'h17, 8'h03, 8'h17, 8'h13};

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  ddr_cmd_if link();
  ddr_cmd_if bad_if();

  sched_ctrl u_sched_ctrl (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_auto_pre(req_auto_pre), .req_ready(req_ready),
    .cmd_illegal(cmd_illegal), .pins(link.ctrl));
  sched_dev u_sched_dev (.clk(clk), .reset_n(reset_n), .pins(link.dev),
    .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_bank(exec_bank),
    .bank_idle(bank_idle), .bank_busy(bank_busy));
  sched_dev u_sched_dev_bad (.clk(clk), .reset_n(reset_n),
    .pins(bad_if.dev), .exec_valid(x_valid), .exec_cmd(x_cmd),
    .exec_bank(x_bank), .bank_idle(), .bank_busy());
  sched_monitor u_sched_monitor (.clk(clk), .reset_n(reset_n),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .bank(link.bank),
    .auto_pre(link.auto_pre));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input cmd_t c, input logic [2:0] b, input logic a);
    int k;
    k = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_auto_pre = a;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    cmp(8'(req_ready), 8'h01);
    exp_q.push_back({c, b});
  endtask

  task automatic refuse(input cmd_t c, input logic [2:0] b);
    int k;
    k = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    @(negedge clk);
    while (cmd_illegal !== 1'b1 && k < 10)
    begin
      cmp(8'(req_ready), 8'h00);
      @(negedge clk);
      k++;
    end
    cmp(8'(cmd_illegal), 8'h01);
    req_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic stop_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Every executed command must match the order of accepted requests
  always @(negedge clk)
    if (exec_valid === 1'b1)
      cmp(8'({exec_cmd, exec_bank}), exp_q.size() ? 8'(exp_q.pop_front())
          : 8'hFF);

  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    req_bank = 3'h0;
    req_auto_pre = 1'b0;
    bad_if.cke = 1'b1;
    {bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} = PAT_NOP;
    bad_if.bank = 3'h5;
    bad_if.auto_pre = 1'b0;
    repeat (16) @(negedge clk);
    cmp(8'({req_ready, link.cs_n}), 8'h01);
    cmp(bank_idle, 8'hFF);
    reset_n = 1'b1;
    $display("test reset done");
    repeat (12) @(negedge clk);
    foreach (rows[i])
    begin
      issue(rows[i].cmd, rows[i].bank, rows[i].ap);
      if (rows[i].gap != 8'h00)
        cmp(8'(cyc - last), rows[i].gap);
      last = cyc;
    end
    req_valid = 1'b0;
    $display("test table done");
    repeat (30) @(negedge clk);
    cmp(bank_idle, 8'hEE);
    cmp(bank_busy, 8'h00);
    issue(CMD_RD, 3'h0, 1'b1);
    req_valid = 1'b0;
    repeat (2) @(negedge clk);
    cmp(bank_busy, 8'h01);
    // Access period of a BL8 read with auto precharge is four clocks
    repeat (3) @(negedge clk);
    cmp(bank_busy, 8'h01);
    @(negedge clk);
    cmp(bank_busy, 8'h00);
    repeat (30) @(negedge clk);
    cmp(bank_idle, 8'hEF);
    $display("test auto precharge done");
    refuse(CMD_RD, 3'h5);
    refuse(CMD_REF, 3'h0);
    refuse(CMD_ACT, 3'h4);
    issue(CMD_PRE, 3'h4, 1'b0);
    req_valid = 1'b0;
    repeat (10) @(negedge clk);
    issue(CMD_REF, 3'h0, 1'b0);
    req_valid = 1'b0;
    repeat (5) @(negedge clk);
    $display("test refusal done");
    // Far end fed deselect, nop, an activate with clock enable low, a nop,
    // then a clean activate; only the last may execute
    foreach (far[i])
    begin
      bad_if.cke = far[i][4];
      {bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} = far[i][3:0];
      @(negedge clk);
      {bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} = PAT_NOP;
      bad_if.cke = 1'b1;
      cmp(8'({x_valid, (x_valid === 1'b1) ? {x_cmd, x_bank} : 6'h00}),
          (i == 4) ? 8'({1'b1, CMD_ACT, 3'h5}) : 8'h00);
      @(negedge clk);
    end
    $display("test far end done");
    // Every accepted request must have been executed by the device end
    cmp(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule
